// *** hdl/adc_path_ctrl.sv ***
// Purpose: Control of the stereo converter input path, mono mixing and output routing.
// Assumes: Control pins and converter samples are synchronous to i_mclk.
// Notes:   Serial control is write only; settings drive the analogue, converter and interface control outputs and the sample path.
`timescale 1ns/10ps
`default_nettype none
module adc_path_ctrl #(
   parameter int SAMPLE_W = 24
) (
   // Clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_nrst,
   // Serial control port
   input  wire logic                    i_ctl_cs_n,
   input  wire logic                    i_ctl_sclk,
   input  wire logic                    i_ctl_sdin,
   // Converter samples in
   input  wire logic                    i_sample_valid,
   output logic                         o_sample_ready,
   input  wire logic [SAMPLE_W-1:0]     i_left_sample,
   input  wire logic [SAMPLE_W-1:0]     i_right_sample,
   // Routed samples out to the audio interface
   output logic                         o_out_valid,
   input  wire logic                    i_out_ready,
   output logic [SAMPLE_W-1:0]          o_out_left,
   output logic [SAMPLE_W-1:0]          o_out_right,
   // Analogue input path controls
   output logic [1:0]                   o_left_input_select,
   output logic [1:0]                   o_right_input_select,
   output logic [1:0]                   o_left_mic_gain,
   output logic [1:0]                   o_right_mic_gain,
   output logic                         o_left_mic_enable,
   output logic                         o_right_mic_enable,
   output logic                         o_left_bypass_closed,
   output logic                         o_right_bypass_closed,
   output logic                         o_left_gain_from_direct,
   output logic                         o_right_gain_from_direct,
   output logic [1:0]                   o_mic_stage_bias_level,
   output logic                         o_left_dc_route,
   output logic                         o_right_dc_route,
   output logic                         o_left_first_bias_en,
   output logic                         o_right_first_bias_en,
   // Converter, clock and interface controls
   output logic                         o_right_converter_power,
   output logic                         o_osr_128,
   output logic                         o_usb_clock_mode,
   output logic [4:0]                   o_rate_code,
   output logic [1:0]                   o_audio_format,
   output logic                         o_audio_master,
   output logic                         o_enhance_enable
);
   // Serial control shifter
   logic                   sclk_q_r;
   logic                   cs_q_r;
   logic [15:0]            shift_r;
   logic [4:0]             bits_r;
   logic                   sclk_rise;
   logic                   wr_stb;
   logic [6:0]             wr_addr;
   logic [8:0]             wr_data;

   assign sclk_rise = i_ctl_sclk & ~sclk_q_r & ~i_ctl_cs_n;
   // A word counts only when exactly sixteen bits were clocked in
   assign wr_stb    = i_ctl_cs_n & ~cs_q_r & (bits_r == adc_path_pkg::CTL_WORD_BITS);
   assign wr_addr   = shift_r[15:adc_path_pkg::CTL_DATA_W];
   assign wr_data   = shift_r[adc_path_pkg::CTL_DATA_W-1:0];

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         sclk_q_r <= 1'b0;
         cs_q_r   <= 1'b1;
         shift_r  <= 16'h0000;
         bits_r   <= 5'h00;
      end else begin
         sclk_q_r <= i_ctl_sclk;
         cs_q_r   <= i_ctl_cs_n;
         if (i_ctl_cs_n & ~cs_q_r) begin
            bits_r <= 5'h00;
         end else if (sclk_rise && bits_r != 5'h1f) begin
            bits_r <= bits_r + 5'h01;
         end
         if (sclk_rise) begin
            shift_r <= {shift_r[14:0], i_ctl_sdin};
         end
      end
   end

   // Register file
   logic [8:0] lpath_r;
   logic [8:0] rpath_r;
   logic [8:0] adcc_r;
   logic [8:0] pwr_r;
   logic [8:0] fmt_r;
   logic [8:0] clk_r;
   logic [8:0] mic_r;
   logic [8:0] dcb_r;
   logic [8:0] enh_r;
   logic       wr_lpath;
   logic       wr_rpath;
   logic       wr_adcc;
   logic       wr_pwr;
   logic       wr_fmt;
   logic       wr_clk;
   logic       wr_mic;
   logic       wr_dcb;
   logic       wr_enh;

   assign wr_lpath = wr_stb & (wr_addr == adc_path_pkg::ADDR_LEFT_PATH);
   assign wr_rpath = wr_stb & (wr_addr == adc_path_pkg::ADDR_RIGHT_PATH);
   assign wr_adcc  = wr_stb & (wr_addr == adc_path_pkg::ADDR_ADC_CTRL);
   assign wr_pwr   = wr_stb & (wr_addr == adc_path_pkg::ADDR_POWER);
   assign wr_fmt   = wr_stb & (wr_addr == adc_path_pkg::ADDR_AUDIO_FMT);
   assign wr_clk   = wr_stb & (wr_addr == adc_path_pkg::ADDR_CLOCK);
   assign wr_mic   = wr_stb & (wr_addr == adc_path_pkg::ADDR_MIC_PATH);
   assign wr_dcb   = wr_stb & (wr_addr == adc_path_pkg::ADDR_DC_BIAS);
   assign wr_enh   = wr_stb & (wr_addr == adc_path_pkg::ADDR_ENHANCE);

   // Unmapped addresses are dropped silently
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         lpath_r <= adc_path_pkg::RST_CHAN_PATH;
         rpath_r <= adc_path_pkg::RST_CHAN_PATH;
         adcc_r  <= adc_path_pkg::RST_ADC_CTRL;
         pwr_r   <= adc_path_pkg::RST_POWER;
         fmt_r   <= adc_path_pkg::RST_AUDIO_FMT;
         clk_r   <= adc_path_pkg::RST_CLOCK;
         mic_r   <= adc_path_pkg::RST_MIC_PATH;
         dcb_r   <= adc_path_pkg::RST_DC_BIAS;
         enh_r   <= adc_path_pkg::RST_ENHANCE;
      end else begin
         if (wr_lpath) lpath_r <= wr_data;
         if (wr_rpath) rpath_r <= wr_data;
         if (wr_adcc)  adcc_r  <= wr_data;
         if (wr_pwr)   pwr_r   <= wr_data;
         if (wr_fmt)   fmt_r   <= wr_data;
         if (wr_clk)   clk_r   <= wr_data;
         if (wr_mic)   mic_r   <= wr_data;
         if (wr_dcb)   dcb_r   <= wr_data;
         if (wr_enh)   enh_r   <= wr_data;
      end
   end

   // Field decode
   logic [1:0] mono_mode;
   logic       is_stereo;
   logic       is_amix;
   logic       is_dmix;
   logic       hpf_off;
   logic       right_output_source;
   logic       low_power_select;
   logic       left_bypass_enable;
   logic       right_bypass_enable;

   assign mono_mode           = adcc_r[adc_path_pkg::ADC_MONO_LSB +: 2];
   assign is_stereo           = (mono_mode == adc_path_pkg::MONO_STEREO);
   assign is_amix             = (mono_mode == adc_path_pkg::MONO_AMIX);
   assign is_dmix             = (mono_mode == adc_path_pkg::MONO_DMIX);
   assign hpf_off             = adcc_r[adc_path_pkg::ADC_HPF_OFF];
   assign right_output_source = adcc_r[adc_path_pkg::ADC_R_SRC];
   assign low_power_select    = adcc_r[adc_path_pkg::ADC_LOW_PWR];
   assign left_bypass_enable  = mic_r[adc_path_pkg::MIC_L_BYP];
   assign right_bypass_enable = mic_r[adc_path_pkg::MIC_R_BYP];

   // Analogue path controls
   assign o_left_input_select  = lpath_r[adc_path_pkg::CH_SEL_LSB +: 2];
   assign o_right_input_select = rpath_r[adc_path_pkg::CH_SEL_LSB +: 2];
   assign o_left_mic_gain      = lpath_r[adc_path_pkg::CH_GAIN_LSB +: 2];
   assign o_right_mic_gain     = rpath_r[adc_path_pkg::CH_GAIN_LSB +: 2];
   assign o_left_mic_enable    = lpath_r[adc_path_pkg::CH_MIC_EN];
   assign o_right_mic_enable   = rpath_r[adc_path_pkg::CH_MIC_EN];
   // Switch closes only while its preamp is off, so preamp and bypass never fight
   assign o_left_bypass_closed     = left_bypass_enable & ~o_left_mic_enable;
   assign o_right_bypass_closed    = right_bypass_enable & ~o_right_mic_enable;
   assign o_left_gain_from_direct  = ~left_bypass_enable;
   assign o_right_gain_from_direct = ~right_bypass_enable;
   assign o_mic_stage_bias_level   = mic_r[adc_path_pkg::MIC_BIAS_LSB +: 2];
   // Dc route bypasses preamp and gain stage; scaling is analogue
   assign o_left_dc_route  = lpath_r[adc_path_pkg::CH_DC_MODE];
   assign o_right_dc_route = rpath_r[adc_path_pkg::CH_DC_MODE] | is_amix;
   assign o_left_first_bias_en  = dcb_r[adc_path_pkg::DCB_LEFT];
   assign o_right_first_bias_en = dcb_r[adc_path_pkg::DCB_RIGHT];

   // Converter, clock and interface controls
   assign o_right_converter_power = pwr_r[adc_path_pkg::PWR_RIGHT_ADC];
   assign o_osr_128        = ~low_power_select;
   assign o_usb_clock_mode = clk_r[adc_path_pkg::CLK_USB];
   assign o_rate_code      = clk_r[adc_path_pkg::CLK_RATE_LSB +: 5];
   assign o_audio_format   = fmt_r[adc_path_pkg::FMT_LSB +: 2];
   assign o_audio_master   = fmt_r[adc_path_pkg::FMT_MASTER];
   assign o_enhance_enable = enh_r[adc_path_pkg::ENH_EN] & is_stereo;

   // High pass filter per channel
   logic                       in_take;
   logic signed [SAMPLE_W-1:0] ch_in  [2];
   logic signed [SAMPLE_W-1:0] ch_flt [2];

   assign in_take  = i_sample_valid & o_sample_ready;
   assign ch_in[0] = i_left_sample;
   assign ch_in[1] = i_right_sample;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : hpf
         logic signed [SAMPLE_W-1:0] off_r;
         logic signed [SAMPLE_W:0]   diff;
         logic signed [SAMPLE_W:0]   step;
         assign diff      = {ch_in[g][SAMPLE_W-1], ch_in[g]} - {off_r[SAMPLE_W-1], off_r};
         assign step      = diff >>> adc_path_pkg::HPF_SHIFT;
         // Dc passes untouched when off, needed for dc measurement
         assign ch_flt[g] = hpf_off ? ch_in[g] : diff[SAMPLE_W-1:0];
         // Offset estimate keeps tracking while off, so re-enable settles fast
         always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
               off_r <= '0;
            end else if (in_take) begin
               off_r <= off_r + step[SAMPLE_W-1:0];
            end
         end
      end
   endgenerate

   // Mixing and output routing
   logic signed [SAMPLE_W:0]   mix_sum;
   logic signed [SAMPLE_W-1:0] mix_smp;
   logic signed [SAMPLE_W-1:0] route_left;
   logic signed [SAMPLE_W-1:0] route_right;
   logic [2*SAMPLE_W-1:0]      push_data;
   logic [2*SAMPLE_W-1:0]      pop_data;

   assign mix_sum     = {ch_flt[0][SAMPLE_W-1], ch_flt[0]} + {ch_flt[1][SAMPLE_W-1], ch_flt[1]};
   assign mix_smp     = mix_sum[SAMPLE_W:1];
   assign route_left  = is_dmix ? mix_smp : ch_flt[0];
   assign route_right = is_dmix ? mix_smp :
                        (is_amix && right_output_source) ? ch_flt[0] :
                        ch_flt[1];
   assign push_data   = {route_left, route_right};

   pair_buffer #(
      .WIDTH (2*SAMPLE_W)
   ) u_buf (
      .i_mclk      (i_mclk),
      .i_nrst      (i_nrst),
      .i_in_valid  (i_sample_valid),
      .o_in_ready  (o_sample_ready),
      .i_in_data   (push_data),
      .o_out_valid (o_out_valid),
      .i_out_ready (i_out_ready),
      .o_out_data  (pop_data)
   );

   assign o_out_left  = pop_data[2*SAMPLE_W-1:SAMPLE_W];
   assign o_out_right = pop_data[SAMPLE_W-1:0];

   // Checks
   sequence mic_write_s;
      wr_mic;
   endsequence

   write_apply_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      wr_stb && wr_addr == adc_path_pkg::ADDR_MIC_PATH |=> mic_r == $past(wr_data))
      else $error("path register write not applied");

   bypass_open_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      mic_write_s ##0 !wr_data[adc_path_pkg::MIC_R_BYP]
      |=> o_right_gain_from_direct && !o_right_bypass_closed)
      else $error("right bypass not opened");

   left_direct_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      mic_write_s ##0 !wr_data[adc_path_pkg::MIC_L_BYP]
      |=> o_left_gain_from_direct && !o_left_bypass_closed)
      else $error("left direct input not selected");

   bias_reset_a: assert property (@(posedge i_mclk)
      !i_nrst |=> o_mic_stage_bias_level == 2'h3)
      else $error("bias level not full after reset");

   enhance_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      mono_mode != adc_path_pkg::MONO_STEREO |-> !o_enhance_enable)
      else $error("enhancement active in mono mode");

   amix_dc_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      is_amix |-> o_right_dc_route)
      else $error("right converter not on dc in mix mode");

   dmix_both_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      in_take && is_dmix |-> route_left == route_right)
      else $error("digital mix differs between channels");

   amix_copy_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      in_take && is_amix && right_output_source |-> route_right == route_left)
      else $error("right output not a copy of left");

   stereo_route_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      in_take && is_stereo && hpf_off
      |-> route_left == i_left_sample && route_right == i_right_sample)
      else $error("stereo routing crossed");

   osr_select_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      wr_adcc |=> o_osr_128 == !$past(wr_data[adc_path_pkg::ADC_LOW_PWR]))
      else $error("oversampling rate not following low power bit");

   power_bit_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      wr_pwr |=> o_right_converter_power == $past(wr_data[adc_path_pkg::PWR_RIGHT_ADC]))
      else $error("right converter power not following bit 2");

   // Taken into an empty buffer, the pair stands at the outputs one cycle later
   sequence take_empty_s;
      in_take && hpf_off && !o_out_valid;
   endsequence

   stereo_land_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      take_empty_s ##0 is_stereo
      |=> o_out_left == $past(i_left_sample) && o_out_right == $past(i_right_sample))
      else $error("stereo pair not delivered unchanged");

   amix_land_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      take_empty_s ##0 is_amix && !right_output_source
      |=> o_out_left == $past(i_left_sample) && o_out_right == $past(i_right_sample))
      else $error("right converter data not on right output");

   short_word_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      i_ctl_cs_n && !cs_q_r && bits_r != adc_path_pkg::CTL_WORD_BITS
      |=> $stable(mic_r) && $stable(adcc_r))
      else $error("short control word was applied");
endmodule
`default_nettype wire

// *** hdl/adc_path_pkg.sv ***
// Purpose: Shared constants and types for the stereo converter input path control.
// Assumes: 7-bit register addresses and 9-bit register data on the serial control port.
// Notes:   Register reset values and field positions live here only.
package adc_path_pkg;

   // Register addresses
   localparam logic [6:0] ADDR_LEFT_PATH  = 7'h00;
   localparam logic [6:0] ADDR_RIGHT_PATH = 7'h01;
   localparam logic [6:0] ADDR_ADC_CTRL   = 7'h05;
   localparam logic [6:0] ADDR_POWER      = 7'h06;
   localparam logic [6:0] ADDR_AUDIO_FMT  = 7'h07;
   localparam logic [6:0] ADDR_CLOCK      = 7'h08;
   localparam logic [6:0] ADDR_MIC_PATH   = 7'h09;
   localparam logic [6:0] ADDR_DC_BIAS    = 7'h0a;
   localparam logic [6:0] ADDR_ENHANCE    = 7'h0b;

   // Reset values
   localparam logic [8:0] RST_CHAN_PATH = 9'h000;
   localparam logic [8:0] RST_ADC_CTRL  = 9'h000;
   localparam logic [8:0] RST_POWER     = 9'h004;
   localparam logic [8:0] RST_AUDIO_FMT = 9'h000;
   localparam logic [8:0] RST_CLOCK     = 9'h000;
   localparam logic [8:0] RST_MIC_PATH  = 9'h00f;
   localparam logic [8:0] RST_DC_BIAS   = 9'h003;
   localparam logic [8:0] RST_ENHANCE   = 9'h000;

   // Per-channel path register fields
   localparam int CH_SEL_LSB   = 0;
   localparam int CH_GAIN_LSB  = 2;
   localparam int CH_MIC_EN    = 4;
   localparam int CH_DC_MODE   = 5;
   // Converter control fields
   localparam int ADC_HPF_OFF  = 0;
   localparam int ADC_R_SRC    = 1;
   localparam int ADC_LOW_PWR  = 2;
   localparam int ADC_MONO_LSB = 7;
   // Power, microphone path, dc bias, enhancement fields
   localparam int PWR_RIGHT_ADC = 2;
   localparam int MIC_R_BYP     = 3;
   localparam int MIC_L_BYP     = 2;
   localparam int MIC_BIAS_LSB  = 0;
   localparam int DCB_LEFT      = 0;
   localparam int DCB_RIGHT     = 1;
   localparam int ENH_EN        = 0;
   // Audio format and clock fields
   localparam int FMT_LSB       = 0;
   localparam int FMT_MASTER    = 6;
   localparam int CLK_USB       = 0;
   localparam int CLK_RATE_LSB  = 1;

   // Mono mode field codes
   localparam logic [1:0] MONO_STEREO = 2'h0;
   localparam logic [1:0] MONO_SINGLE = 2'h1;
   localparam logic [1:0] MONO_DMIX   = 2'h2;
   localparam logic [1:0] MONO_AMIX   = 2'h3;

   // Serial control word
   localparam logic [4:0] CTL_WORD_BITS = 5'h10;
   localparam int         CTL_DATA_W    = 9;

   // Digital filter
   localparam int SAMPLE_W   = 24;
   localparam int HPF_SHIFT  = 10;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } sample_pair_t;

endpackage

// *** hdl/pair_buffer.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Read data comes from a register, so the receiver sees flopped data.
`timescale 1ns/10ps
`default_nettype none
module pair_buffer #(
   parameter int WIDTH = 48
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_nrst,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   logic [WIDTH-1:0] mem_r [2];
   logic             wr_ptr_r;
   logic             rd_ptr_r;
   logic [1:0]       count_r;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count_r != 2'h2);
   assign o_out_valid = (count_r != 2'h0);
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
            wr_ptr_r        <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// *** verif/audio_sink.sv ***
// Purpose: Receiver model on the audio side of the converter path control.
// Assumes: Pairs are taken at an edge where valid and ready are both high.
// Notes:   Ready can toggle every cycle to model a slow receiver.
`timescale 1ns/10ps
`default_nettype none
module audio_sink (
   // Clock, reset and behaviour controls
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_stall,
   input  wire logic        i_slow,
   // Routed samples
   input  wire logic        i_valid,
   output logic             o_ready,
   input  wire logic [23:0] i_left,
   input  wire logic [23:0] i_right
);
   adc_path_pkg::sample_pair_t rx_q[$];
   logic                       ready_r;

   always @(posedge i_mclk) begin
      if (!i_nrst) begin
         ready_r <= 1'b0;
      end else begin
         if (i_valid && ready_r) begin
            rx_q.push_back({i_left, i_right});
         end
         ready_r <= !i_stall && (!i_slow || !ready_r);
      end
   end
   assign o_ready = ready_r;
endmodule
`default_nettype wire

// *** verif/tb_adc_path_ctrl.sv ***
// Purpose: Self-checking bench for the converter input path control.
// Assumes: The bench keeps the host's obligations when it writes registers.
// Notes:   Samples stay below 2^22 so the digital mix never overflows.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_path_ctrl;
   logic        i_mclk, i_nrst, i_ctl_cs_n, i_ctl_sclk, i_ctl_sdin, i_sample_valid;
   logic        i_out_ready, o_sample_ready, o_out_valid, stall, slow, src;
   logic [23:0] i_left_sample, i_right_sample, o_out_left, o_out_right, a, b;
   logic [1:0]  o_left_input_select, o_right_input_select, o_left_mic_gain, o_right_mic_gain;
   logic [1:0]  o_mic_stage_bias_level, o_audio_format, md;
   logic        o_left_mic_enable, o_right_mic_enable, o_left_bypass_closed;
   logic        o_right_bypass_closed, o_left_gain_from_direct, o_right_gain_from_direct;
   logic        o_left_dc_route, o_right_dc_route, o_left_first_bias_en, o_right_first_bias_en;
   logic        o_right_converter_power, o_osr_128, o_usb_clock_mode, o_audio_master;
   logic        o_enhance_enable;
   logic [4:0]  o_rate_code, rt;
   logic [8:0]  d;
   logic [5:0]  pl, pr;
   logic [11:0] ev;
   int          seed, n_fail, checked;
   adc_path_pkg::sample_pair_t exp_q[$];

   adc_path_ctrl adc_path_ctrl_i (.*);
   audio_sink audio_sink_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_stall(stall), .i_slow(slow),
      .i_valid(o_out_valid), .o_ready(i_out_ready), .i_left(o_out_left), .i_right(o_out_right));

   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   function automatic logic [11:0] cfg();
      return {3'h0, o_left_bypass_closed, o_right_bypass_closed, o_left_gain_from_direct,
         o_right_gain_from_direct, o_mic_stage_bias_level, o_left_first_bias_en,
         o_right_first_bias_en, o_right_converter_power};
   endfunction

   function automatic logic [11:0] pth();
      return {o_left_dc_route, o_left_mic_enable, o_left_mic_gain, o_left_input_select,
         o_right_dc_route, o_right_mic_enable, o_right_mic_gain, o_right_input_select};
   endfunction

   function automatic adc_path_pkg::sample_pair_t route(input logic [1:0] m, input logic s,
      input logic [23:0] l, input logic [23:0] r);
      logic [24:0] sum;
      sum = {1'b0, l} + {1'b0, r};
      if (m == adc_path_pkg::MONO_DMIX) return {sum[24:1], sum[24:1]};
      if (m == adc_path_pkg::MONO_AMIX && s) return {l, l};
      return {l, r};
   endfunction

   task automatic report_and_stop();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic timeout();
      n_fail++;
      $display("BAD %0t wait %h %h", $time, 1'b0, 1'b1);
      report_and_stop();
   endtask

   task automatic chk_v(input logic [11:0] g, input logic [11:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_p(input adc_path_pkg::sample_pair_t g, input adc_path_pkg::sample_pair_t e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Serial word, MSB first; a short count models a truncated word
   task automatic wr(input logic [6:0] ad, input logic [8:0] dt, input int n);
      logic [15:0] w;
      w = {ad, dt};
      @(posedge i_mclk);
      i_ctl_cs_n <= 1'b0;
      for (int k = 15; k > 15 - n; k--) begin
         @(posedge i_mclk);
         i_ctl_sclk <= 1'b0;
         i_ctl_sdin <= w[k];
         @(posedge i_mclk);
         i_ctl_sclk <= 1'b1;
      end
      @(posedge i_mclk);
      i_ctl_cs_n <= 1'b1;
      i_ctl_sclk <= 1'b0;
      i_ctl_sdin <= ~w[0];
      repeat (3) @(posedge i_mclk);
      #1;
   endtask

   // Ready is sampled mid-cycle so the taking edge is known without a race
   task automatic send(input logic [23:0] l, input logic [23:0] r,
      input adc_path_pkg::sample_pair_t e);
      int   t;
      logic ok;
      @(posedge i_mclk);
      i_sample_valid <= 1'b1;
      i_left_sample <= l;
      i_right_sample <= r;
      exp_q.push_back(e);
      t = 0;
      do begin
         @(negedge i_mclk);
         ok = o_sample_ready;
         @(posedge i_mclk);
         t++;
      end while (ok !== 1'b1 && t < 64);
      i_sample_valid <= 1'b0;
      if (ok !== 1'b1) timeout();
   endtask

   task automatic drain();
      int t;
      for (t = 0; t < 300 && audio_sink_i.rx_q.size() < exp_q.size(); t++) @(posedge i_mclk);
      if (t == 300) timeout();
      while (exp_q.size() > 0) chk_p(audio_sink_i.rx_q.pop_front(), exp_q.pop_front());
   endtask

   initial begin
      seed = 48;
      n_fail = 0;
      checked = 0;
      i_nrst = 1'b0;
      i_ctl_cs_n = 1'b1;
      {stall, slow, i_ctl_sclk, i_ctl_sdin, i_sample_valid} = '0;
      {i_left_sample, i_right_sample} = '0;
      repeat (6) @(posedge i_mclk);
      i_nrst <= 1'b1;
      @(posedge i_mclk);
      #1;
      chk_v(cfg(), 12'h19f);
      chk_v({11'h0, o_osr_128}, 12'h001);
      a = 24'($random(seed)) & 24'h3f_ffff;
      b = 24'($random(seed)) & 24'h3f_ffff;
      send(a, b, {a, b});
      send(a, b, {a - (a >> 10), b - (b >> 10)});
      drain();
      for (int i = 0; i < 8; i++) begin
         pl = 6'($random(seed));
         pr = 6'($random(seed));
         d = 9'($random(seed));
         if (pl[4] | pr[4]) d[3:2] = 2'h3;
         wr(adc_path_pkg::ADDR_LEFT_PATH, {3'h0, pl}, 16);
         wr(adc_path_pkg::ADDR_RIGHT_PATH, {3'h0, pr}, 16);
         wr(adc_path_pkg::ADDR_MIC_PATH, {5'h0, d[3:0]}, 16);
         ev = {3'h0, d[2] & ~pl[4], d[3] & ~pr[4], ~d[2], ~d[3], d[1:0], 3'h7};
         chk_v(pth(), {pl, pr});
         chk_v(cfg(), ev);
      end
      wr(adc_path_pkg::ADDR_MIC_PATH, 9'h000, 15);
      wr(7'h7f, 9'h000, 16);
      chk_v(cfg(), ev);
      wr(adc_path_pkg::ADDR_RIGHT_PATH, 9'h000, 16);
      wr(adc_path_pkg::ADDR_DC_BIAS, 9'h002, 16);
      wr(adc_path_pkg::ADDR_POWER, 9'h000, 16);
      chk_v(cfg() & 12'h007, 12'h002);
      rt = 5'($random(seed));
      wr(adc_path_pkg::ADDR_ADC_CTRL, {6'h00, ~rt[4], 2'h0}, 16);
      wr(adc_path_pkg::ADDR_AUDIO_FMT, {2'h0, 1'b1, 4'h0, rt[1:0]}, 16);
      wr(adc_path_pkg::ADDR_CLOCK, {3'h0, rt, rt[4]}, 16);
      chk_v({2'h0, o_osr_128, o_usb_clock_mode, o_rate_code, o_audio_master, o_audio_format},
         {2'h0, rt[4], rt[4], rt, 1'b1, rt[1:0]});
      wr(adc_path_pkg::ADDR_POWER, 9'h004, 16);
      wr(adc_path_pkg::ADDR_ENHANCE, 9'h001, 16);
      for (int m = 0; m < 8; m++) begin
         md = 2'(m >> 1);
         src = m[0] & (md != adc_path_pkg::MONO_STEREO);
         wr(adc_path_pkg::ADDR_ADC_CTRL, {md, 5'h0, src, 1'b1}, 16);
         chk_v({10'h0, o_enhance_enable, o_right_dc_route},
            {10'h0, md == adc_path_pkg::MONO_STEREO, md == adc_path_pkg::MONO_AMIX});
         @(posedge i_mclk);
         slow <= 1'($random(seed));
         repeat (3) begin
            a = 24'($random(seed)) & 24'h3f_ffff;
            b = 24'($random(seed)) & 24'h3f_ffff;
            send(a, b, route(md, src, a, b));
         end
         drain();
      end
      // Receiver stalls: two pairs must sit in the buffer and input ready drops, so a third would be refused
      @(posedge i_mclk);
      stall <= 1'b1;
      repeat (2) send(a, ~a & 24'h3f_ffff, route(md, src, a, ~a & 24'h3f_ffff));
      @(negedge i_mclk);
      chk_v({10'h0, o_sample_ready, o_out_valid}, 12'h001);
      @(posedge i_mclk);
      stall <= 1'b0;
      drain();
      report_and_stop();
   end
endmodule
`default_nettype wire
